//--- pkg/dcm_pkg.sv
// ============================================================
// Shared constants of the dual clock mode controller.
`default_nettype none
package dcm_pkg;

   // ============================================================
   // Register map. The printed offset is a register index, so the
   // byte address on the bus is four times the index.
   localparam logic [7:0] OSC_MODE_INDEX = 8'hCA;
   localparam logic [31:0] OSC_MODE_ADDR = 32'h0000_0328;
   localparam logic [7:0] OSC_MODE_RESET = 8'h00;
   localparam int HIGH_OSC_STOP_BIT = 1;
   localparam int SLOW_SEL_BIT = 2;
   localparam int POWER_MODE_LSB = 3;

   // ============================================================
   // Operating mode field encodings.
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_SLEEP = 2'h1;
   localparam logic [1:0] PM_GREEN = 2'h2;

   // ============================================================
   // High clock type options.
   localparam logic [1:0] HC_RC = 2'h0;
   localparam logic [1:0] HC_32K = 2'h1;
   localparam logic [1:0] HC_12M = 2'h2;
   localparam logic [1:0] HC_4M = 2'h3;

   // ============================================================
   // Cycle counts, in edges of the selected oscillator.
   localparam int SLOW_DIV = 4;
   localparam int WAKE_CYCLES = 2048;
   localparam int BOOT_CYCLES_RC = 32;
   localparam int BOOT_CYCLES_XTAL = 2048;
   localparam int MAX_CPU_DIV = 8;
   localparam int NOISE_MAX_DIV = 4;

   // ============================================================
   // Bus answers.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_BOOT,
      ST_RUN,
      ST_SLEEP,
      ST_WARMUP,
      ST_GREEN
   } dcm_state_type;

endpackage
`default_nettype wire

//--- rtl/dcm_clock_control.sv
`timescale 1ns/1ps
`default_nettype none
module dcm_clock_control #(
   parameter logic [1:0] HIGH_CLOCK_TYPE = dcm_pkg::HC_4M,
   parameter int CPU_DIV = 4,
   parameter bit NOISE_FILTER = 1'b0,
   parameter bit WATCHDOG_EN = 1'b1,
   parameter int ADDR_W = 12
)(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic osc_input_pin,
   input wire logic internal_low_rc,
   input wire logic wake_request,
   output logic high_osc_enable,
   output logic internal_low_rc_enable,
   output logic osc_output_pin_release,
   output logic watchdog_clock_pulse,
   output logic cpu_tick,
   output logic cpu_run,
   output logic slow_clock_active
);

   // ============================================================
   // Build-option checks.
   generate
      if (CPU_DIV < 1 || CPU_DIV > dcm_pkg::MAX_CPU_DIV ||
         (NOISE_FILTER && CPU_DIV > dcm_pkg::NOISE_MAX_DIV))
      begin : g_bad_div
         $error("Divider must be 1 to 8, 1 to 4 filtered.");
      end
      if (ADDR_W < 10 || ADDR_W > 32)
      begin : g_bad_addr
         $error("Address width must lie from 10 to 32.");
      end
   endgenerate

   // The type option sets how long boot waits for the oscillator.
   localparam int BOOT_CYCLES = (HIGH_CLOCK_TYPE == dcm_pkg::HC_RC) ?
      dcm_pkg::BOOT_CYCLES_RC : dcm_pkg::BOOT_CYCLES_XTAL;
   localparam bit LOW_MAY_STOP_GREEN =
      (HIGH_CLOCK_TYPE == dcm_pkg::HC_32K) && !WATCHDOG_EN;
   localparam logic [2:0] NORM_LAST = 3'(CPU_DIV - 1);
   localparam logic [2:0] SLOW_LAST = 3'(dcm_pkg::SLOW_DIV - 1);
   localparam logic [11:0] WAKE_LAST = 12'(dcm_pkg::WAKE_CYCLES - 1);
   localparam logic [11:0] BOOT_LAST = 12'(BOOT_CYCLES - 1);

   typedef struct packed {
      dcm_pkg::dcm_state_type state;
      logic [2:0] high_sync;
      logic [2:0] low_sync;
      logic [2:0] wake_sync;
      logic high_level;
      logic low_level;
      logic wake_level;
      logic [2:0] div_cnt;
      logic [11:0] warm_cnt;
      logic tick;
      logic active_slow;
      logic high_osc_stop;
      logic slow_sel;
      logic [1:0] power_mode;
      logic high_osc_en;
      logic low_rc_en;
      logic out_pin_release;
      logic run;
      logic wdt_pulse;
      logic aw_got;
      logic aw_hit;
      logic w_got;
      logic [7:0] wdata;
      logic wstrb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } dcm_regs_type;

   dcm_regs_type r;
   dcm_regs_type next_r;

   // ============================================================
   // Helpers.
   // A pin change counts only once the second and third stages agree,
   // which rejects a single metastable sample.
   function automatic logic settle(input logic [2:0] s, input logic old);
      settle = (s[1] == s[2]) ? s[2] : old;
   endfunction

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      addr_hit = (a[ADDR_W-1:2] == dcm_pkg::OSC_MODE_ADDR[ADDR_W-1:2]);
   endfunction

   function automatic logic [7:0] reg_image(input dcm_regs_type q);
      logic [7:0] v;
      v = 8'h00;
      v[dcm_pkg::HIGH_OSC_STOP_BIT] = q.high_osc_stop;
      v[dcm_pkg::SLOW_SEL_BIT] = q.slow_sel;
      v[dcm_pkg::POWER_MODE_LSB +: 2] = q.power_mode;
      reg_image = v;
   endfunction

   // ============================================================
   // Next-state logic.
   // One edge of the selected oscillator advances the divider; the
   // source and operating mode only change when the divider wraps or on
   // a wake from sleep or green, so the instruction clock never sees a runt period.
   always_comb
   begin
      logic high_edge;
      logic low_edge;
      logic src_edge;
      logic [2:0] last;
      logic [11:0] warm_last;
      high_edge = 1'b0;
      low_edge = 1'b0;
      src_edge = 1'b0;
      last = 3'h0;
      warm_last = (r.state == dcm_pkg::ST_BOOT) ? BOOT_LAST :
         WAKE_LAST;
      next_r = r;
      next_r.tick = 1'b0;
      next_r.wdt_pulse = 1'b0;
      // Both clocks enter from outside and pass three stages.
      next_r.high_sync = {r.high_sync[1:0], osc_input_pin};
      next_r.low_sync = {r.low_sync[1:0], internal_low_rc};
      next_r.wake_sync = {r.wake_sync[1:0], wake_request};
      next_r.high_level = settle(r.high_sync, r.high_level);
      next_r.low_level = settle(r.low_sync, r.low_level);
      next_r.wake_level = settle(r.wake_sync, r.wake_level);
      high_edge = next_r.high_level && !r.high_level;
      low_edge = next_r.low_level && !r.low_level;
      next_r.wdt_pulse = low_edge;
      src_edge = r.active_slow ? low_edge : high_edge;
      last = r.active_slow ? SLOW_LAST : NORM_LAST;

      case (r.state)
         dcm_pkg::ST_BOOT, dcm_pkg::ST_WARMUP:
         begin
            // Both waits count settled high edges, so they share one counter.
            if (high_edge)
            begin
               if (r.warm_cnt == warm_last)
               begin
                  next_r.state = dcm_pkg::ST_RUN;
                  next_r.warm_cnt = 12'h000;
               end
               else
                  next_r.warm_cnt = r.warm_cnt + 12'h001;
            end
         end
         dcm_pkg::ST_RUN:
         begin
            if (src_edge)
            begin
               if (r.div_cnt == last)
               begin
                  next_r.div_cnt = 3'h0;
                  next_r.tick = 1'b1;
                  next_r.active_slow = r.slow_sel;
                  // The reserved code falls through as normal.
                  case (r.power_mode)
                     dcm_pkg::PM_SLEEP: next_r.state = dcm_pkg::ST_SLEEP;
                     dcm_pkg::PM_GREEN: next_r.state = dcm_pkg::ST_GREEN;
                     default: next_r.state = dcm_pkg::ST_RUN;
                  endcase
               end
               else
                  next_r.div_cnt = r.div_cnt + 3'h1;
            end
         end
         dcm_pkg::ST_SLEEP:
         begin
            // Sleep always returns to normal mode on the high clock.
            if (r.wake_level)
            begin
               next_r.state = dcm_pkg::ST_WARMUP;
               next_r.warm_cnt = 12'h000;
               next_r.power_mode = dcm_pkg::PM_NORMAL;
               next_r.slow_sel = 1'b0;
               next_r.active_slow = 1'b0;
               next_r.div_cnt = 3'h0;
            end
         end
         dcm_pkg::ST_GREEN:
         begin
            // No warm-up wait is taken, so resume at once in the last mode.
            if (r.wake_level)
            begin
               next_r.state = dcm_pkg::ST_RUN;
               next_r.power_mode = dcm_pkg::PM_NORMAL;
            end
         end
         default:
            next_r.state = dcm_pkg::ST_BOOT;
      endcase

      // Write channel; a write after the wake clear wins over it.
      if (s_axi_awvalid && r.awready)
      begin
         next_r.aw_got = 1'b1;
         next_r.aw_hit = addr_hit(s_axi_awaddr);
      end
      if (s_axi_wvalid && r.wready)
      begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata[7:0];
         next_r.wstrb0 = s_axi_wstrb[0];
      end
      if (r.bvalid && s_axi_bready)
         next_r.bvalid = 1'b0;
      if (r.aw_got && r.w_got && !r.bvalid)
      begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = r.aw_hit ? dcm_pkg::RESP_OKAY :
            dcm_pkg::RESP_SLVERR;
         if (r.aw_hit && r.wstrb0)
         begin
            next_r.high_osc_stop = r.wdata[dcm_pkg::HIGH_OSC_STOP_BIT];
            next_r.slow_sel = r.wdata[dcm_pkg::SLOW_SEL_BIT];
            next_r.power_mode = r.wdata[dcm_pkg::POWER_MODE_LSB +: 2];
         end
      end
      next_r.awready = !next_r.aw_got && !next_r.bvalid;
      next_r.wready = !next_r.w_got && !next_r.bvalid;

      // Read channel; unused bits of the register read as zero.
      if (r.rvalid && s_axi_rready)
         next_r.rvalid = 1'b0;
      if (s_axi_arvalid && r.arready)
      begin
         next_r.rvalid = 1'b1;
         next_r.rdata = addr_hit(s_axi_araddr) ? reg_image(r) : 8'h00;
         next_r.rresp = addr_hit(s_axi_araddr) ? dcm_pkg::RESP_OKAY :
            dcm_pkg::RESP_SLVERR;
      end
      next_r.arready = !next_r.rvalid;

      // Oscillator enables follow state and, for the high one, the stop bit;
      // the low oscillator has no enable bit of its own.
      next_r.high_osc_en = (next_r.state != dcm_pkg::ST_SLEEP) &&
         (!next_r.high_osc_stop || next_r.state == dcm_pkg::ST_BOOT ||
         next_r.state == dcm_pkg::ST_WARMUP);
      next_r.low_rc_en = (next_r.state != dcm_pkg::ST_SLEEP) &&
         !(next_r.state == dcm_pkg::ST_GREEN && LOW_MAY_STOP_GREEN);
      next_r.out_pin_release = (HIGH_CLOCK_TYPE == dcm_pkg::HC_RC);
      // Registered so that the run flag leaves no decode glitch on its pin.
      next_r.run = (next_r.state == dcm_pkg::ST_RUN);
   end

   // ============================================================
   // State register.
   always_ff @(posedge ref_clk)
   begin
      if (!resetn)
         r <= '0;
      else
         r <= next_r;
   end

   // ============================================================
   // Outputs, all taken straight from the state register.
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bresp = r.bresp;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_arready = r.arready;
   assign s_axi_rdata = {24'h000000, r.rdata};
   assign s_axi_rresp = r.rresp;
   assign s_axi_rvalid = r.rvalid;
   assign high_osc_enable = r.high_osc_en;
   assign internal_low_rc_enable = r.low_rc_en;
   assign osc_output_pin_release = r.out_pin_release;
   assign watchdog_clock_pulse = r.wdt_pulse;
   assign cpu_tick = r.tick;
   assign cpu_run = r.run;
   assign slow_clock_active = r.active_slow;

   // ============================================================
   // Checks.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   AST_SLOW_DIV: assert property (
      (r.tick && $past(r.active_slow)) |-> $past(r.div_cnt) == SLOW_LAST)
      else $error("Slow tick not after four low edges.");
   AST_NORM_DIV: assert property (
      (r.tick && !$past(r.active_slow)) |-> $past(r.div_cnt) == NORM_LAST)
      else $error("Normal tick not after N high edges.");
   AST_RESERVED_ZERO: assert property (
      r.rvalid |-> (r.rdata[0] == 1'b0 && r.rdata[7:5] == 3'h0))
      else $error("Unused register bits read nonzero.");
   AST_HIGH_STOP: assert property (
      (r.state == dcm_pkg::ST_RUN && r.high_osc_stop) |->
      (!r.high_osc_en && r.low_rc_en))
      else $error("High oscillator runs while stopped.");
   AST_SLEEP_OFF: assert property (
      (r.state == dcm_pkg::ST_SLEEP) |-> (!r.high_osc_en && !r.low_rc_en))
      else $error("Oscillator running in sleep.");
   AST_WARM_LEN: assert property (
      (r.state == dcm_pkg::ST_RUN &&
      $past(r.state) == dcm_pkg::ST_WARMUP) |-> $past(r.warm_cnt) == WAKE_LAST)
      else $error("Sleep wakeup did not wait 2048 edges.");
   AST_GREEN_FAST: assert property (
      (r.state == dcm_pkg::ST_GREEN && r.wake_level) |=>
      (r.state == dcm_pkg::ST_RUN && $stable(r.active_slow)))
      else $error("Green wakeup delayed or changed mode.");
   AST_RESERVED_RUN: assert property (
      (r.state == dcm_pkg::ST_RUN && r.power_mode == 2'h3) |=>
      r.state == dcm_pkg::ST_RUN)
      else $error("Reserved mode code left normal run.");
   AST_LOW_STOP: assert property (
      (!r.low_rc_en && r.state != dcm_pkg::ST_BOOT) |->
      (r.state == dcm_pkg::ST_SLEEP || (r.state == dcm_pkg::ST_GREEN &&
      LOW_MAY_STOP_GREEN)))
      else $error("Low oscillator stopped outside allowed modes.");
   AST_SWITCH: assert property (
      $changed(r.active_slow) |-> (r.tick ||
      $past(r.state) == dcm_pkg::ST_SLEEP))
      else $error("Clock source switched mid instruction.");

endmodule // dcm_clock_control
`default_nettype wire

//--- test/dcm_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Behavioural crystal and internal RC oscillator on the far side.
module dcm_osc_model #(
   parameter int HALF_HIGH = 5,
   parameter int HALF_LOW = 10
)(
   input wire logic ref_clk,
   input wire logic high_enable,
   input wire logic low_enable,
   output logic high_clock,
   output logic low_clock
);
   int high_count = 0;
   int low_count = 0;
   logic high_q = 1'b0;
   logic low_q = 1'b0;

   // A stopped oscillator stands still low, so no rising edge can leak out.
   always @(posedge ref_clk)
   begin
      if (high_enable !== 1'b1)
      begin
         high_count <= 0;
         high_q <= 1'b0;
      end
      else if (high_count == HALF_HIGH - 1)
      begin
         high_count <= 0;
         high_q <= ~high_q;
      end
      else
         high_count <= high_count + 1;
      if (low_enable !== 1'b1)
      begin
         low_count <= 0;
         low_q <= 1'b0;
      end
      else if (low_count == HALF_LOW - 1)
      begin
         low_count <= 0;
         low_q <= ~low_q;
      end
      else
         low_count <= low_count + 1;
   end

   // Outputs follow the internal state directly.
   assign high_clock = high_q;
   assign low_clock = low_q;
endmodule // dcm_osc_model
`default_nettype wire

//--- test/dual_clock_mode_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Register-level test of the dual clock mode controller.
module dual_clock_mode_control_test;
   localparam int CPU_DIV = 3;
   localparam int HH = 5;
   localparam int HL = 10;
   localparam logic [11:0] REG = dcm_pkg::OSC_MODE_ADDR[11:0];
   localparam logic [1:0] OK = dcm_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = dcm_pkg::RESP_SLVERR;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] s_axi_awaddr = '0;
   logic [11:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic wake_request = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, osc_input_pin, internal_low_rc, high_osc_enable;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic internal_low_rc_enable, osc_output_pin_release, cpu_tick;
   logic watchdog_clock_pulse, cpu_run, slow_clock_active;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;

   // ============================================================
   // Clock, design and oscillator model.
   always #12.5 ref_clk = ~ref_clk;

   dcm_clock_control #(
      .HIGH_CLOCK_TYPE(dcm_pkg::HC_RC),
      .CPU_DIV(CPU_DIV)
   ) dcm_clock_control_i (
      .ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .osc_input_pin, .internal_low_rc,
      .wake_request, .high_osc_enable, .internal_low_rc_enable,
      .osc_output_pin_release, .watchdog_clock_pulse, .cpu_tick,
      .cpu_run, .slow_clock_active
   );

   dcm_osc_model #(.HALF_HIGH(HH), .HALF_LOW(HL)) dcm_osc_model_i (
      .ref_clk(ref_clk),
      .high_enable(high_osc_enable),
      .low_enable(internal_low_rc_enable),
      .high_clock(osc_input_pin),
      .low_clock(internal_low_rc)
   );

   // ============================================================
   // Reporting.
   task automatic print_verdict();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // A hang anywhere counts as a mismatch and ends the run.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 50000)
      begin
         num_errors++;
         print_verdict();
      end
   end

   // ============================================================
   // Bus cycles. Ready and valid are read just after the edge, so
   // they show the values that the edge itself sampled.
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge ref_clk);
         aw_done = aw_done | (s_axi_awready === 1'b1);
         w_done = w_done | (s_axi_wready === 1'b1);
         if (aw_done)
            s_axi_awvalid <= 1'b0;
         if (w_done)
            s_axi_wvalid <= 1'b0;
      end
      // Raised only now, so back-to-back writes never set it twice at once.
      s_axi_bready <= 1'b1;
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check("write resp", s_axi_bresp, r);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check("read data", s_axi_rdata, {24'h0, d});
      check("read resp", s_axi_rresp, r);
   endtask

   function automatic logic pulse(input bit wd);
      return wd ? watchdog_clock_pulse : cpu_tick;
   endfunction

   // The first gap is skipped so that a pending mode change has landed.
   task automatic gap(input bit wd, output int n);
      for (int k = 0; k < 2; k++)
         do @(posedge ref_clk); while (pulse(wd) !== 1'b1);
      @(posedge ref_clk);
      for (n = 1; pulse(wd) !== 1'b1 && n < 1000; n++) @(posedge ref_clk);
   endtask

   task automatic wait_run(input logic lvl, output int n);
      for (n = 0; cpu_run !== lvl && n < 30000; n++) @(posedge ref_clk);
   endtask

   // ============================================================
   // Main sequence.
   initial
   begin
      int n;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check("pin release", osc_output_pin_release, 1);
      check("high enable", high_osc_enable, 1);
      check("low enable", internal_low_rc_enable, 1);
      rd(REG, 8'h00, OK);
      wait_run(1'b1, n);
      check("boot time", n >= 280 && n <= 400, 1);
      gap(0, n);
      check("normal gap", n, CPU_DIV * 2 * HH);
      check("normal source", slow_clock_active, 0);
      gap(1, n);
      check("watchdog gap", n, 2 * HL);
      wr(REG, 32'h04, 4'h1, OK);
      gap(0, n);
      check("slow gap", n, 4 * 2 * HL);
      check("slow source", slow_clock_active, 1);
      wr(REG, 32'h06, 4'h1, OK);
      gap(1, n);
      check("stopped high", high_osc_enable, 0);
      check("low running", internal_low_rc_enable, 1);
      check("watchdog gap", n, 2 * HL);
      // Green mode entered from slow mode with the high clock stopped.
      wr(REG, 32'h16, 4'h1, OK);
      wait_run(1'b0, n);
      check("green entry", n < 200, 1);
      check("green low", internal_low_rc_enable, 1);
      wake_request <= 1'b1;
      wait_run(1'b1, n);
      check("green wake", n <= 8, 1);
      wake_request <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd(REG, 8'h06, OK);
      check("slow kept", slow_clock_active, 1);
      // Settle wait scaled down; the full time would swamp the run.
      wr(REG, 32'h04, 4'h1, OK);
      repeat (200) @(posedge ref_clk);
      wr(REG, 32'h00, 4'h1, OK);
      gap(0, n);
      check("normal again", n, CPU_DIV * 2 * HH);
      // Back to slow first: stopping the high clock in normal mode would
      // stall the instruction clock and the mode change with it.
      wr(REG, 32'h04, 4'h1, OK);
      gap(0, n);
      check("slow again", n, 4 * 2 * HL);
      // Every bit written: only bits 1 to 4 hold, code 11 keeps running.
      wr(REG, 32'hFF, 4'h1, OK);
      rd(REG, 8'h1E, OK);
      gap(0, n);
      check("reserved run", cpu_run, 1);
      check("reserved slow", n, 4 * 2 * HL);
      wr(REG, 32'h04, 4'h1, OK);
      repeat (200) @(posedge ref_clk);
      wr(REG, 32'h00, 4'h1, OK);
      wr(12'h000, 32'h5A, 4'h1, ERR);
      rd(12'h000, 8'h00, ERR);
      wr(REG, 32'h04, 4'h0, OK);
      rd(REG, 8'h00, OK);
      // Sleep stops both oscillators; wake waits the full warm-up.
      wr(REG, 32'h08, 4'h1, OK);
      wait_run(1'b0, n);
      repeat (4) @(posedge ref_clk);
      check("sleep high", high_osc_enable, 0);
      check("sleep low", internal_low_rc_enable, 0);
      wake_request <= 1'b1;
      wait_run(1'b1, n);
      check("warm-up", n >= 20400 && n <= 20600, 1);
      wake_request <= 1'b0;
      rd(REG, 8'h00, OK);
      check("wake normal", slow_clock_active, 0);
      print_verdict();
   end
endmodule // dual_clock_mode_control_test
`default_nettype wire
